// >>> pkg/pis_pkg.sv
// package: register map, field layout and types of the persistent interrupt flag block
package pis_pkg;

   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [7:0] PIS_OFF_STATUS  = 8'h00;
   localparam logic [7:0] PIS_OFF_CLEAR   = 8'h04;
   localparam logic [7:0] PIS_OFF_ENABLE  = 8'h08;
   localparam logic [7:0] PIS_OFF_CONTROL = 8'h0C;
   localparam logic [7:0] PIS_OFF_LEVELS  = 8'h10;
   localparam logic [7:0] PIS_OFF_COND    = 8'h14;

   // ----------------------------------------
   // flag bit positions in status, clear, enable and condition
   // ----------------------------------------
   localparam int PIS_FLAG_COUNT    = 8;
   localparam int PIS_BIT_CAPTURE   = 0;
   localparam int PIS_BIT_SPI_RX    = 1;
   localparam int PIS_BIT_SPI_TX    = 2;
   localparam int PIS_BIT_SER_RX    = 3;
   localparam int PIS_BIT_SER_TX    = 4;
   localparam int PIS_BIT_ADC       = 5;
   localparam int PIS_BIT_PARALLEL  = 6;
   localparam int PIS_BIT_SER_ERR   = 7;

   // ----------------------------------------
   // level select field positions (two bits each) in the levels register
   // ----------------------------------------
   localparam int PIS_POS_CAPTURE_SEL = 0;
   localparam int PIS_POS_SPI_RX_SEL  = 2;
   localparam int PIS_POS_SPI_TX_SEL  = 4;
   localparam int PIS_POS_SER_RX_SEL  = 6;
   localparam int PIS_POS_SER_TX_SEL  = 8;

   // control register: bit 0 enables the serial port module
   localparam int PIS_POS_SER_ENABLE = 0;

   // ----------------------------------------
   // interrupt request numbers of the serial peripheral interface
   // ----------------------------------------
   localparam logic [7:0] PIS_IRQ_SPI_RX_DONE = 8'h18;
   localparam logic [7:0] PIS_IRQ_SPI_TX_DONE = 8'h19;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [31:0] PIS_RST_WORD = 32'h0000_0000;
   localparam logic [31:0] PIS_DECERR  = 32'h0000_0000;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   // first member is the top bit: listed high to low so the bits match the positions above
   typedef struct packed {
      logic       ser_err;
      logic       parallel;
      logic       adc;
      logic       ser_tx;
      logic       ser_rx;
      logic       spi_tx;
      logic       spi_rx;
      logic       capture;
   } pis_flags_t;

   typedef struct packed {
      logic [1:0] serial_tx_irq_level_select;
      logic [1:0] serial_rx_irq_level_select;
      logic [1:0] spi_tx_irq_level_select;
      logic [1:0] spi_rx_irq_level_select;
      logic [1:0] capture_irq_count_select;
   } pis_levels_t;

   // buffer fill counts reported by the peripherals
   typedef struct packed {
      logic [3:0] capture_count;
      logic [3:0] spi_rx_count;
      logic [3:0] spi_tx_free;
      logic [3:0] ser_rx_count;
      logic [3:0] ser_tx_free;
      logic [4:0] adc_unread;
      logic       parallel_pending;
   } pis_counts_t;

   typedef struct packed {
      logic       pready;
      logic [31:0] prdata;
      logic       pslverr;
   } pis_apb_rsp_t;

endpackage

// >>> rtl/pis_flags.sv
// persistent interrupt flag block: sticky flags held while source conditions stand
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pis_flags
   import pis_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire pis_counts_t counts,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   output logic             irq,
   output logic [7:0]       spi_rx_irq_number,
   output logic [7:0]       spi_tx_irq_number,
   output pis_flags_t       irq_flags
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      pis_flags_t   status;
      pis_flags_t   enable;
      pis_levels_t  levels;
      logic         ser_enable;
      pis_apb_rsp_t rsp;
      logic         irq;
      logic [7:0]   spi_rx_num;
      logic [7:0]   spi_tx_num;
   } pis_state_t;

   pis_state_t st;
   pis_state_t next_st;

   // ----------------------------------------
   // threshold decode
   // ----------------------------------------
   // level code n means: source active while count exceeds n (0 means any entry)
   function automatic logic pis_above(input logic [3:0] count, input logic [1:0] sel);
      pis_above = count > {2'h0, sel};
   endfunction

   logic       acc;
   logic       wr;
   pis_flags_t cond;
   logic [31:0] rdata;
   logic       hit;

   always_comb begin
      acc = psel & penable;
      wr  = acc & pwrite;

      // ----------------------------------------
      // source conditions
      // ----------------------------------------
      cond          = '0;
      cond.capture  = pis_above(counts.capture_count,
                                st.levels.capture_irq_count_select);
      cond.spi_rx   = pis_above(counts.spi_rx_count,
                                st.levels.spi_rx_irq_level_select);
      cond.spi_tx   = pis_above(counts.spi_tx_free,
                                st.levels.spi_tx_irq_level_select);
      cond.ser_rx   = pis_above(counts.ser_rx_count,
                                st.levels.serial_rx_irq_level_select);
      // tx free space counts from the moment the port is on, no write needed
      cond.ser_tx   = st.ser_enable & pis_above(counts.ser_tx_free,
                                st.levels.serial_tx_irq_level_select);
      cond.adc      = counts.adc_unread != 5'h00;
      cond.parallel = counts.parallel_pending;
      cond.ser_err  = 1'b0;

      // ----------------------------------------
      // read mux
      // ----------------------------------------
      hit   = 1'b1;
      rdata = PIS_RST_WORD;
      unique case (paddr)
         PIS_OFF_STATUS:  rdata = {24'h00_0000, st.status};
         PIS_OFF_CLEAR:   rdata = PIS_RST_WORD;
         PIS_OFF_ENABLE:  rdata = {24'h00_0000, st.enable};
         PIS_OFF_CONTROL: rdata = {31'h0000_0000, st.ser_enable};
         PIS_OFF_LEVELS:  rdata = {22'h00_0000, st.levels};
         PIS_OFF_COND:    rdata = {24'h00_0000, cond};
         default: begin
            hit   = 1'b0;
            rdata = PIS_DECERR;
         end
      endcase

      next_st = st;

      // ----------------------------------------
      // apb slave: zero wait states, answered in the first access cycle
      // ----------------------------------------
      next_st.rsp.pready  = psel & ~penable;
      next_st.rsp.prdata  = (psel & ~penable & ~pwrite) ? rdata : PIS_RST_WORD;
      next_st.rsp.pslverr = psel & ~penable & ~hit;

      if (wr & st.rsp.pready & hit) begin
         unique case (paddr)
            PIS_OFF_CLEAR: begin
               // a clear only lands on flags whose condition is gone
               next_st.status = st.status & ~(pwdata[7:0] & ~cond);
            end
            PIS_OFF_ENABLE:  next_st.enable = pwdata[7:0];
            PIS_OFF_CONTROL: next_st.ser_enable = pwdata[PIS_POS_SER_ENABLE];
            PIS_OFF_LEVELS:  next_st.levels = pwdata[9:0];
            default: begin
               next_st.enable = st.enable;
            end
         endcase
      end

      // set wins over clear; a standing condition sets every cycle
      next_st.status = next_st.status | cond;

      next_st.irq        = |(next_st.status & next_st.enable);
      next_st.spi_rx_num = PIS_IRQ_SPI_RX_DONE;
      next_st.spi_tx_num = PIS_IRQ_SPI_TX_DONE;
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // pready rises in the access cycle itself since it was computed in setup
   assign pready            = st.rsp.pready;
   assign prdata            = st.rsp.prdata;
   assign pslverr           = st.rsp.pslverr;
   assign irq               = st.irq;
   assign spi_rx_irq_number = st.spi_rx_num;
   assign spi_tx_irq_number = st.spi_tx_num;
   assign irq_flags         = st.status;

endmodule
`default_nettype wire

// >>> bench/pis_flags_assertions.sv
// checker: port-level properties of the persistent flag block
`timescale 1ns/1ps
`default_nettype none
module pis_chk
   import pis_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire pis_counts_t counts,
   input wire logic [7:0]  spi_rx_irq_number,
   input wire logic [7:0]  spi_tx_irq_number,
   input wire pis_flags_t  irq_flags
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // a clear can only land in an access cycle aimed at the clear word
   wire logic clr_wr = psel && penable && pwrite && paddr == PIS_OFF_CLEAR;
   property p_num; $past(presetn) |-> {spi_rx_irq_number, spi_tx_irq_number} == 16'h1819; endproperty
   a_num: assert property (p_num) else $error("irq numbers");
   property p_cap; counts.capture_count > 4'h3 |=> irq_flags.capture; endproperty
   a_cap: assert property (p_cap) else $error("capture flag");
   property p_sprx; counts.spi_rx_count > 4'h3 |=> irq_flags.spi_rx; endproperty
   a_sprx: assert property (p_sprx) else $error("spi rx flag");
   property p_sptx; counts.spi_tx_free > 4'h3 |=> irq_flags.spi_tx; endproperty
   a_sptx: assert property (p_sptx) else $error("spi tx flag");
   property p_serrx; counts.ser_rx_count > 4'h3 |=> irq_flags.ser_rx; endproperty
   a_serrx: assert property (p_serrx) else $error("serial rx flag");
   property p_adc; counts.adc_unread != 5'h00 |=> irq_flags.adc; endproperty
   a_adc: assert property (p_adc) else $error("adc flag");
   property p_par; counts.parallel_pending |=> irq_flags.parallel; endproperty
   a_par: assert property (p_par) else $error("parallel flag");
   property p_fell; $fell(irq_flags.adc) |-> $past(clr_wr) && $past(counts.adc_unread) == 5'h00; endproperty
   a_fell: assert property (p_fell) else $error("flag cleared early");
endmodule
bind pis_flags pis_chk u_chk(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .counts(counts), .spi_rx_irq_number(spi_rx_irq_number),
   .spi_tx_irq_number(spi_tx_irq_number), .irq_flags(irq_flags));
`default_nettype wire

// >>> bench/pis_periph_model.sv
// peripheral side model: buffer fill counts seen by the flag block
`timescale 1ns/1ps
`default_nettype none
module pis_periph_model
   import pis_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        load,
   input  wire pis_counts_t load_val,
   input  wire logic        drain,
   output var pis_counts_t  counts
);
   // one drain cycle stands for one software read of the adc and parallel buffers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         counts <= '0;
      end else if (load) begin
         counts <= load_val;
      end else if (drain) begin
         counts.adc_unread <= counts.adc_unread - 5'(counts.adc_unread != 5'h00);
         counts.parallel_pending <= 1'h0;
      end
   end
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench of the persistent flag block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import pis_pkg::*;
   logic        pclk = 1'h0, presetn = 1'h0, load = 1'h0, drain = 1'h0;
   logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   pis_counts_t load_val = '0;
   pis_counts_t counts;
   logic        pready, pslverr, irq;
   logic [31:0] prdata;
   logic [7:0]  rx_num, tx_num;
   pis_flags_t  flags;
   logic [31:0] exp_q[$];
   int          fails = 0;
   int          samples_checked = 0;
   logic [3:0]  cap;
   logic        last_err = 1'h0;
   always #2 pclk = ~pclk;
   pis_periph_model u_model(.pclk(pclk), .presetn(presetn), .load(load), .load_val(load_val),
      .drain(drain), .counts(counts));
   pis_flags u_dut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .counts(counts), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .irq(irq), .spi_rx_irq_number(rx_num),
      .spi_tx_irq_number(tx_num), .irq_flags(flags));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // reads queue their expectation; the monitor below compares at the answer
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, e);
      int n;
      n = 0;
      if (!w) exp_q.push_back(e);
      psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin @(posedge pclk); n++; end while (pready !== 1'h1 && n < 50);
      if (pready !== 1'h1) begin fails++; print_verdict(); end
      last_err = pslverr;
      psel <= 1'h0; penable <= 1'h0;
      @(posedge pclk);
   endtask
   task automatic put(input pis_counts_t v);
      load_val <= v; load <= 1'h1;
      @(posedge pclk);
      load <= 1'h0;
      repeat (2) @(posedge pclk);
   endtask
   always @(posedge pclk) if (psel && penable && pready === 1'h1 && !pwrite)
      chk(prdata, exp_q.pop_front());
   initial begin
      void'($urandom(32'h178c_1f4c));
      repeat (16) @(posedge pclk);
      presetn <= 1'h1;
      repeat (2) @(posedge pclk);
      chk({16'h0000, rx_num, tx_num}, 32'h0000_1819);
      bus(1'h0, PIS_OFF_STATUS, 32'h0, 32'h0000_0000);
      bus(1'h1, PIS_OFF_LEVELS, 32'h0000_00f6, 32'h0);
      bus(1'h1, PIS_OFF_ENABLE, 32'h0000_00ff, 32'h0);
      cap = 4'h4 + 4'($urandom % 12);
      put({cap, 4'h4, 4'h4, 4'h4, 4'h1, 5'h02, 1'h1});
      bus(1'h1, PIS_OFF_CLEAR, 32'h0000_00ff, 32'h0);
      bus(1'h0, PIS_OFF_STATUS, 32'h0, 32'h0000_006f);
      chk({31'h0, irq}, 32'h0000_0001);
      $display("test standing conditions done");
      // counts land exactly on the capture, spi rx, spi tx and serial rx levels: a count equal to the level means no condition
      put({4'h2, 4'h1, 4'h3, 4'h3, 4'h1, 5'h02, 1'h1});
      drain <= 1'h1;
      repeat (2) @(posedge pclk);
      drain <= 1'h0;
      bus(1'h1, PIS_OFF_CLEAR, 32'h0000_00ff, 32'h0);
      bus(1'h0, PIS_OFF_STATUS, 32'h0, 32'h0000_0000);
      chk({31'h0, irq}, 32'h0000_0000);
      $display("test drained done");
      bus(1'h1, PIS_OFF_CONTROL, 32'h0000_0001, 32'h0);
      bus(1'h0, PIS_OFF_STATUS, 32'h0, 32'h0000_0010);
      chk({24'h00_0000, flags}, 32'h0000_0010);
      bus(1'h0, PIS_OFF_COND, 32'h0, 32'h0000_0010);
      bus(1'h1, PIS_OFF_CLEAR, 32'h0000_0010, 32'h0);
      bus(1'h0, PIS_OFF_STATUS, 32'h0, 32'h0000_0010);
      bus(1'h0, PIS_OFF_LEVELS, 32'h0, 32'h0000_00f6);
      bus(1'h0, PIS_OFF_CLEAR, 32'h0, 32'h0000_0000);
      bus(1'h0, 8'hfc, 32'h0, 32'h0000_0000);
      chk({31'h0, last_err}, 32'h0000_0001);
      bus(1'h0, PIS_OFF_ENABLE, 32'h0, 32'h0000_00ff);
      chk({31'h0, last_err}, 32'h0000_0000);
      $display("test serial enable done");
      print_verdict();
   end
endmodule
`default_nettype wire
